// File: logic/csb_regs.svh
// Register offsets, field positions, reset values and fixed addresses
// of the sideband pin block. Assumes a 32-bit APB with byte addresses.
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH

`define CSB_CTRL_OFS      12'h000
`define CSB_STATUS_OFS    12'h004
`define CSB_PERR_OFS      12'h008

`define CSB_CTRL_PROT     0
`define CSB_CTRL_PG       1
`define CSB_CTRL_CD       2
`define CSB_CTRL_BASE_PCD 3
`define CSB_CTRL_BASE_PWT 4
`define CSB_CTRL_EXT_WRITE_BUF_EMPTY_N_MSK 5
`define CSB_CTRL_RST      6'h00

`define CSB_ST_NMI_PEND   0
`define CSB_ST_NMI_BUSY   1
`define CSB_ST_SMI_PEND   2
`define CSB_ST_SMM        3
`define CSB_ST_TRISTATE   4
`define CSB_ST_RESET      5

`define CSB_NMI_VECTOR    8'h02
`define CSB_SMM_BASE      32'h0003_8000
`define CSB_RESET_FETCH   32'hFFFF_FFF0
`define CSB_SYNC_INIT     4'hA

`endif

// File: logic/csb_pkg.sv
// Types shared by the sideband pin block.
// Assumes csb_regs.svh supplies the numeric constants.
package csb_pkg;

   typedef enum logic [1:0] {
      CSB_ACC_NONPAGED,
      CSB_ACC_DIR_4M,
      CSB_ACC_PAGE_4K
   } csb_acc_e;

   typedef enum logic [1:0] {
      CSB_SMI_IDLE,
      CSB_SMI_DRAIN,
      CSB_SMI_EXT_WRITE_BUF_EMPTY_N,
      CSB_SMI_ACTIVE
   } csb_smi_e;

   typedef struct packed {
      csb_acc_e   acc;
      logic       dir_pcd;
      logic       dir_pwt;
      logic       tbl_pcd;
      logic       tbl_pwt;
      logic       locked;
      logic [3:0] nbytes;
      logic [2:0] addr_lo;
   } csb_cyc_s;

   typedef struct packed {
      logic [63:0] data;
      logic [7:0]  par;
      logic [7:0]  lanes_n;
   } csb_rdata_s;

endpackage

// File: logic/csb_sideband.sv
// Processor-side sideband pin logic: interrupt inputs, reset input,
// page attribute, split-cycle and parity-check outputs, APB registers.
// Assumes the core reports cycle starts, instruction boundaries and
// handler returns on pclk; bus pins from the chipset share pclk.
//
// Notes on behaviour
// R01: Urgent interrupt vectors to 02h, no acknowledge
// R02: Urgent interrupt unmaskable, masked in sysmgmt mode
// R03: Repeat urgent interrupt waits for handler return
// R04: Urgent interrupt rising-edge latched, taken at boundary
// R05: Chipset holds urgent interrupt long enough
// R06: Nocache output blocks caching of page
// R07: Nocache source chosen by mode and access
// R08: Writethrough zero unpaged, else per access source
// R09: Attributes driven at strobe, held until done
// R10: Attributes float on backoff or hold acknowledge
// R11: Even parity checked on enabled read bytes
// R12: Parity error only on reads; driven unless test
// R13: One-clock parity error, one edge after ready
// R14: Parity error raises no internal exception
// R15: Reset flushes state, fetch from FFFF_FFF0h
// R16: Test select sampled at reset fall
// R17: Reset is level input, sync or async
// R18: Chipset holds reset long enough
// R19: Split output on misaligned locked transfers
// R20: Split asserts at strobe, ends sequence, floats
// R21: Sysmgmt entry drains, waits buffer, jumps base
// R22: Sysmgmt falling-edge latched, taken at boundary
// R23: Chipset holds sysmgmt interrupt long enough
// R24: Repeat sysmgmt request waits for mode exit
//
// Chosen here: the register offsets and register access over APB.

`timescale 1ns/100ps
`default_nettype none
`include "csb_regs.svh"

module csb_sideband (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Asynchronous pins
   input  wire logic                 urgent_irq_in,
   input  wire logic                 sysmgmt_irq_n,
   input  wire logic                 reset_in,
   input  wire logic                 tristate_test_select_n,
   // Bus pins on pclk
   input  wire logic                 next_addr_n,
   input  wire logic                 burst_ready_n,
   input  wire logic                 backoff_n,
   input  wire logic                 ext_write_buf_empty_n,
   input  wire csb_pkg::csb_rdata_s  rdata,
   // Core side
   input  wire logic                 cyc_start,
   input  wire csb_pkg::csb_cyc_s    cyc,
   input  wire logic                 cyc_last_ready,
   input  wire logic                 lock_seq_last,
   input  wire logic                 cyc_parity_read,
   input  wire logic                 hold_ack,
   input  wire logic                 instr_boundary,
   input  wire logic                 irq_return_done,
   input  wire logic                 sysmgmt_exit_done,
   input  wire logic                 bus_idle,
   // Attribute and status pins
   output logic                      page_nocache_out,
   output logic                      page_nocache_oe,
   output logic                      page_writethru_out,
   output logic                      page_writethru_oe,
   output logic                      split_cycle_out,
   output logic                      split_cycle_oe,
   output logic                      parity_err_n,
   output logic                      parity_err_oe,
   output logic                      sysmgmt_active_n,
   // Core control
   output logic                      take_urgent,
   output logic [7:0]                urgent_vector,
   output logic                      take_sysmgmt,
   output logic                      clear_irq_flag,
   output logic [31:0]               jump_addr,
   output logic                      core_flush,
   output logic                      tristate_mode
);

   // Pin synchronisers, one lane each: urgent, sysmgmt, reset, test
   logic [3:0] pin_raw;
   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic [3:0] pin_s3_reg;
   logic [3:0] pin_reg;
   logic [3:0] pin_prev_reg;

   assign pin_raw = {tristate_test_select_n, reset_in, sysmgmt_irq_n, urgent_irq_in};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_reg   <= `CSB_SYNC_INIT;
         pin_s2_reg   <= `CSB_SYNC_INIT;
         pin_s3_reg   <= `CSB_SYNC_INIT;
         pin_reg      <= `CSB_SYNC_INIT;
         pin_prev_reg <= `CSB_SYNC_INIT;
      end else begin
         pin_s1_reg   <= pin_raw;
         pin_s2_reg   <= pin_s1_reg;
         pin_s3_reg   <= pin_s2_reg;
         // A lane moves only once stages two and three agree
         pin_reg      <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
         pin_prev_reg <= pin_reg;
      end
   end

   logic urgent_rise;
   logic sysmgmt_fall;
   logic rst_lvl;
   logic rst_fall;

   assign urgent_rise  = pin_reg[0] & ~pin_prev_reg[0];   // R04
   assign sysmgmt_fall = ~pin_reg[1] & pin_prev_reg[1];   // R22
   assign rst_lvl      = pin_reg[2];                      // R17
   assign rst_fall     = ~pin_reg[2] & pin_prev_reg[2];

   // Reset input: flush while held, fetch address fixed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_flush <= 1'b1;
      end else begin
         core_flush <= rst_lvl;                            // R15
      end
   end

   // Test select caught at the reset's falling transition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tristate_mode <= 1'b0;
      end else if (rst_lvl) begin
         tristate_mode <= 1'b0;
      end else if (rst_fall) begin
         tristate_mode <= ~pin_reg[3];                     // R16
      end
   end

   // Control register
   logic [5:0] ctrl_reg;
   logic       apb_wr;
   logic       apb_rd;

   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & penable & ~pwrite;
   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CSB_CTRL_RST;
      end else if (rst_lvl) begin
         ctrl_reg <= `CSB_CTRL_RST;                        // R15
      end else if (apb_wr && paddr == `CSB_CTRL_OFS) begin
         ctrl_reg <= pwdata[5:0];
      end
   end

   // Urgent interrupt latch and handler tracking
   logic nmi_pend_reg;
   logic nmi_busy_reg;
   logic nmi_take;
   logic in_smm;

   assign nmi_take = nmi_pend_reg & instr_boundary & ~nmi_busy_reg & ~in_smm;  // R02 R03 R04

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_pend_reg <= 1'b0;
      end else if (rst_lvl) begin
         nmi_pend_reg <= 1'b0;
      end else if (urgent_rise) begin
         nmi_pend_reg <= 1'b1;                              // R04
      end else if (nmi_take) begin
         nmi_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_busy_reg <= 1'b0;
      end else if (rst_lvl) begin
         nmi_busy_reg <= 1'b0;
      end else if (nmi_take) begin
         nmi_busy_reg <= 1'b1;
      end else if (irq_return_done) begin
         nmi_busy_reg <= 1'b0;                              // R03
      end
   end

   // Sysmgmt entry sequence
   csb_pkg::csb_smi_e smi_state;
   logic              smi_pend_reg;
   logic              smi_take;
   logic              ext_write_buf_empty_n_ok;

   assign in_smm   = (smi_state != csb_pkg::CSB_SMI_IDLE);  // R02
   assign smi_take = smi_pend_reg & instr_boundary & ~in_smm;  // R22 R24
   assign ext_write_buf_empty_n_ok  = ~ext_write_buf_empty_n | ctrl_reg[`CSB_CTRL_EXT_WRITE_BUF_EMPTY_N_MSK];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smi_pend_reg <= 1'b0;
      end else if (rst_lvl) begin
         smi_pend_reg <= 1'b0;
      end else if (sysmgmt_fall) begin
         smi_pend_reg <= 1'b1;                              // R22 R24
      end else if (smi_take) begin
         smi_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smi_state <= csb_pkg::CSB_SMI_IDLE;
      end else if (rst_lvl) begin
         smi_state <= csb_pkg::CSB_SMI_IDLE;
      end else begin
         case (smi_state)
            csb_pkg::CSB_SMI_IDLE: begin
               if (smi_take) begin
                  smi_state <= csb_pkg::CSB_SMI_DRAIN;     // R21
               end
            end
            csb_pkg::CSB_SMI_DRAIN: begin
               if (bus_idle) begin
                  smi_state <= csb_pkg::CSB_SMI_EXT_WRITE_BUF_EMPTY_N;
               end
            end
            csb_pkg::CSB_SMI_EXT_WRITE_BUF_EMPTY_N: begin
               if (ext_write_buf_empty_n_ok) begin
                  smi_state <= csb_pkg::CSB_SMI_ACTIVE;    // R21
               end
            end
            default: begin
               if (sysmgmt_exit_done && bus_idle) begin
                  smi_state <= csb_pkg::CSB_SMI_IDLE;      // R24
               end
            end
         endcase
      end
   end

   // Core-facing pulses, vectors and the active pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         take_urgent      <= 1'b0;
         take_sysmgmt     <= 1'b0;
         clear_irq_flag   <= 1'b0;
         urgent_vector    <= 8'h00;
         jump_addr        <= `CSB_RESET_FETCH;
         sysmgmt_active_n <= 1'b1;
      end else begin
         take_urgent      <= nmi_take & ~rst_lvl;          // R01
         urgent_vector    <= `CSB_NMI_VECTOR;              // R01
         take_sysmgmt     <= 1'b0;
         clear_irq_flag   <= 1'b0;
         sysmgmt_active_n <= ~(smi_state == csb_pkg::CSB_SMI_ACTIVE);
         if (rst_lvl) begin
            jump_addr <= `CSB_RESET_FETCH;                  // R15
         end else if (smi_state == csb_pkg::CSB_SMI_EXT_WRITE_BUF_EMPTY_N && ext_write_buf_empty_n_ok) begin
            take_sysmgmt   <= 1'b1;                         // R21
            clear_irq_flag <= 1'b1;
            jump_addr      <= `CSB_SMM_BASE;
         end
      end
   end

   // Page attributes from mode and access category
   logic pg_on;
   logic attr_pcd;
   logic attr_pwt;

   assign pg_on = ctrl_reg[`CSB_CTRL_PROT] & ctrl_reg[`CSB_CTRL_PG];

   always_comb begin
      attr_pcd = ctrl_reg[`CSB_CTRL_CD];                    // R07
      attr_pwt = 1'b0;                                      // R08
      if (pg_on) begin
         case (cyc.acc)
            csb_pkg::CSB_ACC_DIR_4M: begin
               attr_pwt = cyc.dir_pwt;
               if (!ctrl_reg[`CSB_CTRL_CD]) attr_pcd = cyc.dir_pcd;
            end
            csb_pkg::CSB_ACC_PAGE_4K: begin
               attr_pwt = cyc.tbl_pwt;
               if (!ctrl_reg[`CSB_CTRL_CD]) attr_pcd = cyc.tbl_pcd;
            end
            default: begin
               attr_pwt = ctrl_reg[`CSB_CTRL_BASE_PWT];
               if (!ctrl_reg[`CSB_CTRL_CD]) attr_pcd = ctrl_reg[`CSB_CTRL_BASE_PCD];
            end
         endcase
      end
   end

   // Misaligned locked transfer detection
   logic       misaligned;
   logic [3:0] end_ofs;

   assign end_ofs = {2'b00, cyc.addr_lo[1:0]} + cyc.nbytes;

   always_comb begin
      misaligned = 1'b0;                                    // R19
      if (cyc.nbytes == 4'h2 || cyc.nbytes == 4'h4) begin
         misaligned = (end_ofs > 4'h4);
      end else if (cyc.nbytes == 4'h8) begin
         misaligned = (cyc.addr_lo != 3'h0);
      end
   end

   // Attribute and split pins: drive at strobe, hold, float
   logic float_now;
   logic hold_ack_prev;
   logic cyc_done;

   assign float_now = ~backoff_n | (hold_ack & ~hold_ack_prev);  // R10 R20
   assign cyc_done  = ~next_addr_n | (~burst_ready_n & cyc_last_ready);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_ack_prev <= 1'b0;
      end else begin
         hold_ack_prev <= hold_ack;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_nocache_out   <= 1'b0;
         page_writethru_out <= 1'b0;
         page_nocache_oe    <= 1'b0;
         page_writethru_oe  <= 1'b0;
      end else if (float_now || tristate_mode || rst_lvl) begin
         page_nocache_oe   <= 1'b0;                         // R10
         page_writethru_oe <= 1'b0;
      end else if (cyc_start) begin
         // Held past cycle end until the next start or a float
         page_nocache_out   <= attr_pcd;                    // R06 R09
         page_writethru_out <= attr_pwt;                    // R09
         page_nocache_oe    <= 1'b1;
         page_writethru_oe  <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         split_cycle_out <= 1'b0;
         split_cycle_oe  <= 1'b0;
      end else if (float_now || tristate_mode || rst_lvl) begin
         split_cycle_oe <= 1'b0;                            // R20
      end else if (cyc_start) begin
         split_cycle_oe <= 1'b1;
         split_cycle_out <= cyc.locked & (misaligned | split_cycle_out);  // R19 R20
      end else if (split_cycle_out && cyc_done && lock_seq_last) begin
         split_cycle_out <= 1'b0;                           // R20
      end
   end

   // Read parity: one stage to catch, one to drive, glitch-free flop out
   logic [7:0] lane_bad;
   logic       perr_seen_reg;
   logic [15:0] perr_cnt_reg;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         lane_bad[i] = ~rdata.lanes_n[i] & ((^rdata.data[i*8 +: 8]) ^ rdata.par[i]);  // R11
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         perr_seen_reg <= 1'b0;
         parity_err_n  <= 1'b1;
      end else begin
         perr_seen_reg <= ~burst_ready_n & cyc_parity_read & (|lane_bad);  // R12
         parity_err_n  <= ~perr_seen_reg;                   // R13 R14
      end
   end

   assign parity_err_oe = ~tristate_mode;                   // R12

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         perr_cnt_reg <= 16'h0000;
      end else if (perr_seen_reg && perr_cnt_reg != 16'hFFFF) begin
         // Counter saturates so software never sees a wrap
         perr_cnt_reg <= perr_cnt_reg + 16'h0001;
      end
   end

   // APB read mux and error answer
   always_comb begin
      prdata  = 32'h0000_0000;
      pslverr = 1'b0;
      if (paddr == `CSB_CTRL_OFS) begin
         prdata[5:0] = ctrl_reg;
      end else if (paddr == `CSB_STATUS_OFS) begin
         prdata[`CSB_ST_NMI_PEND] = nmi_pend_reg;
         prdata[`CSB_ST_NMI_BUSY] = nmi_busy_reg;
         prdata[`CSB_ST_SMI_PEND] = smi_pend_reg;
         prdata[`CSB_ST_SMM]      = in_smm;
         prdata[`CSB_ST_TRISTATE] = tristate_mode;
         prdata[`CSB_ST_RESET]    = rst_lvl;
      end else if (paddr == `CSB_PERR_OFS) begin
         prdata[15:0] = perr_cnt_reg;
      end else begin
         pslverr = psel & penable;
      end
      if (!apb_rd) begin
         prdata = 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

// File: verif/csb_sideband_monitor.sv
// Checker for the sideband pin block, bound to its top module.
// Assumes one clock, pclk, and the asynchronous active-low presetn.
`timescale 1ns/100ps
`default_nettype none

module csb_sideband_monitor (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Bus and core inputs
   input wire logic        burst_ready_n,
   input wire logic        next_addr_n,
   input wire logic        backoff_n,
   input wire logic        cyc_start,
   input wire logic        lock_seq_last,
   input wire logic        cyc_parity_read,
   input wire logic        hold_ack,
   input wire logic        instr_boundary,
   input wire logic        reset_in,
   // Outputs
   input wire logic        page_nocache_out,
   input wire logic        page_nocache_oe,
   input wire logic        page_writethru_out,
   input wire logic        split_cycle_out,
   input wire logic        split_cycle_oe,
   input wire logic        page_writethru_oe,
   input wire logic        parity_err_n,
   input wire logic        parity_err_oe,
   input wire logic        sysmgmt_active_n,
   input wire logic        take_urgent,
   input wire logic [7:0]  urgent_vector,
   input wire logic        take_sysmgmt,
   input wire logic        clear_irq_flag,
   input wire logic [31:0] jump_addr,
   input wire logic        core_flush,
   input wire logic        tristate_mode
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_urgent_vector: assert property (take_urgent |-> urgent_vector == 8'h02)
      else $error("urgent vector wrong");
   a_urgent_masked: assert property (!sysmgmt_active_n |-> !take_urgent)
      else $error("urgent taken in sysmgmt mode");
   a_urgent_bnd: assert property (take_urgent |-> $past(instr_boundary))
      else $error("urgent taken off a boundary");
   a_attr_hold: assert property (page_nocache_oe && !cyc_start && backoff_n && !hold_ack
      && !core_flush && !tristate_mode |=> !page_nocache_oe
      || ($stable(page_nocache_out) && $stable(page_writethru_out)))
      else $error("attribute changed mid cycle");
   a_float_backoff: assert property (!backoff_n |=>
      !page_nocache_oe && !page_writethru_oe && !split_cycle_oe)
      else $error("attributes driven after backoff");
   a_parity_oe: assert property (parity_err_oe == !tristate_mode)
      else $error("parity pin drive wrong");
   a_parity_cause: assert property ($fell(parity_err_n) |->
      $past(!burst_ready_n, 2) && $past(cyc_parity_read, 2) ##1 parity_err_n)
      else $error("parity pulse without read ready");
   a_flush_rst: assert property (reset_in [*6] |->
      core_flush && jump_addr == 32'hFFFF_FFF0)
      else $error("reset not applied");
   a_split_end: assert property (split_cycle_out && lock_seq_last && !next_addr_n
      && !cyc_start && backoff_n && !hold_ack |=> !split_cycle_out)
      else $error("split not negated");
   a_smi_entry: assert property (take_sysmgmt |-> clear_irq_flag
      ##[0:1] jump_addr == 32'h0003_8000 ##[0:1] !sysmgmt_active_n)
      else $error("sysmgmt entry wrong");

   c_urgent: cover property (take_urgent);
   c_smi: cover property (take_sysmgmt);
   c_parity: cover property ($fell(parity_err_n));
endmodule

bind csb_sideband csb_sideband_monitor u_mon (.*);

`default_nettype wire

// File: verif/csb_chipset_model.sv
// Chipset model: interrupt pins, ready, next address, backoff,
// write buffer status and read data. Assumes the bench calls its tasks.
`timescale 1ns/100ps
`default_nettype none

module csb_chipset_model (
   // Clock
   input wire logic             pclk,
   // Pins toward the processor
   output logic                 urgent_irq_in,
   output logic                 sysmgmt_irq_n,
   output logic                 burst_ready_n,
   output logic                 next_addr_n,
   output logic                 backoff_n,
   output logic                 ext_write_buf_empty_n,
   output csb_pkg::csb_rdata_s  rdata
);
   initial begin
      urgent_irq_in = 1'b0;
      sysmgmt_irq_n = 1'b1;
      burst_ready_n = 1'b1;
      {next_addr_n, backoff_n, ext_write_buf_empty_n} = 3'h7;
      rdata = '0;
   end
   // Two idle then two asserted: safe when sampled asynchronously
   task irq(input logic sm);
      repeat (2) @(posedge pclk);
      if (sm) sysmgmt_irq_n <= 1'b0;
      else urgent_irq_in <= 1'b1;
      repeat (2) @(posedge pclk);
      {urgent_irq_in, sysmgmt_irq_n} <= 2'b01;
   endtask
   // Released data bus shows the inverse, never a stale copy
   task beat(input logic [63:0] d, input logic [7:0] p, input logic [7:0] ln);
      @(posedge pclk);
      burst_ready_n <= 1'b0;
      rdata <= '{data: d, par: p, lanes_n: ln};
      @(posedge pclk);
      burst_ready_n <= 1'b1;
      rdata <= '{data: ~d, par: ~p, lanes_n: ~ln};
   endtask
   task pins(input logic bo, input logic na, input logic wb);
      @(posedge pclk);
      backoff_n <= bo;
      next_addr_n <= na;
      ext_write_buf_empty_n <= wb;
   endtask
endmodule

`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the sideband pin block with a chipset model.
// Assumes csb_regs.svh is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "csb_regs.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
   logic pclk, presetn, psel, penable, pwrite, reset_in, tristate_test_select_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, jump_addr, rd;
   logic [7:0] urgent_vector;
   logic pready, pslverr, cyc_start, cyc_last_ready, lock_seq_last, cyc_parity_read;
   logic hold_ack, instr_boundary, irq_return_done, sysmgmt_exit_done, bus_idle;
   logic urgent_irq_in, sysmgmt_irq_n, burst_ready_n, next_addr_n, backoff_n;
   logic ext_write_buf_empty_n, page_nocache_out, page_nocache_oe, page_writethru_out;
   logic page_writethru_oe, split_cycle_out, split_cycle_oe, parity_err_n, parity_err_oe;
   logic sysmgmt_active_n, take_urgent, take_sysmgmt, clear_irq_flag, core_flush;
   logic tristate_mode, er, s;
   csb_pkg::csb_rdata_s rdata;
   csb_pkg::csb_cyc_s cyc, c;
   int checks, n_fail, i;

   csb_sideband u_dut (.*);
   csb_chipset_model u_cs (.*);

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task close_out();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task ck(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task bnd();
      @(posedge pclk) instr_boundary <= 1'b1;
      @(posedge pclk) instr_boundary <= 1'b0;
      s = 1'b0;
      repeat (3) @(negedge pclk) s |= take_urgent;
   endtask
   task done(input logic sm);
      @(posedge pclk) {irq_return_done, sysmgmt_exit_done} <= {~sm, sm};
      @(posedge pclk) {irq_return_done, sysmgmt_exit_done} <= 2'b00;
   endtask
   task start(input csb_pkg::csb_cyc_s x);
      @(posedge pclk) {cyc_start, cyc} <= {1'b1, x};
      @(posedge pclk) cyc_start <= 1'b0;
      @(negedge pclk);
   endtask
   task par(input logic [7:0] p, input logic [7:0] ln, input logic [3:0] ex);
      logic [3:0] v;
      u_cs.beat(64'h0000_0000_0000_0000, p, ln);
      repeat (4) @(negedge pclk) v = {v[2:0], parity_err_n};
      `CHK(v, ex)
   endtask

   task t_regs();
      apb(1'b0, `CSB_CTRL_OFS, 32'h0);
      `CHK(rd, 32'h0000_0000)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK(er, 1'b1)
      apb(1'b1, `CSB_CTRL_OFS, 32'h0000_0004);
      c = '0;
      c.acc = csb_pkg::CSB_ACC_PAGE_4K;
      start(c);
      `CHK({page_nocache_out, page_writethru_out}, 2'b10)
   endtask
   task t_urgent();
      u_cs.irq(1'b0);
      ck(4);
      bnd();
      `CHK(s, 1'b1)
      `CHK(urgent_vector, 8'h02)
      u_cs.irq(1'b0);
      ck(4);
      bnd();
      `CHK(s, 1'b0)
      done(1'b0);
      bnd();
      `CHK(s, 1'b1)
      done(1'b0);
   endtask
   task t_attr();
      logic [1:0] ex [3];
      ex = '{2'b10, 2'b01, 2'b11};
      apb(1'b1, `CSB_CTRL_OFS, 32'h0000_000B);
      for (i = 0; i < 3; i++) begin
         c = '{acc: csb_pkg::csb_acc_e'(i[1:0]), dir_pwt: 1'b1, tbl_pcd: 1'b1,
               tbl_pwt: 1'b1, default: '0};
         start(c);
         `CHK({page_nocache_out, page_writethru_out}, ex[i])
      end
      u_cs.beat(64'h0000_0000_0000_0000, 8'h00, 8'h00);
      `CHK({page_nocache_oe, page_nocache_out, page_writethru_out}, 3'b111)
      u_cs.pins(1'b0, 1'b1, 1'b1);
      u_cs.pins(1'b1, 1'b1, 1'b1);
      @(negedge pclk);
      `CHK({page_nocache_oe, page_writethru_oe}, 2'b00)
      start(c);
      @(posedge pclk) hold_ack <= 1'b1;
      ck(1);
      @(negedge pclk) `CHK(page_writethru_oe, 1'b0)
      @(posedge pclk) hold_ack <= 1'b0;
   endtask
   task t_split();
      logic [8:0] tb [4];
      tb = '{{4'd4, 3'd2, 2'b11}, {4'd8, 3'd0, 2'b00}, {4'd2, 3'd3, 2'b11},
             {4'd8, 3'd4, 2'b11}};
      for (i = 0; i < 4; i++) begin
         c = '0;
         {c.nbytes, c.addr_lo} = tb[i][8:2];
         c.locked = tb[i][1];
         start(c);
         `CHK(split_cycle_out, tb[i][0])
      end
      @(posedge pclk) lock_seq_last <= 1'b1;
      u_cs.pins(1'b1, 1'b0, 1'b1);
      u_cs.pins(1'b1, 1'b1, 1'b1);
      @(negedge pclk) `CHK(split_cycle_out, 1'b0)
      @(posedge pclk) lock_seq_last <= 1'b0;
   endtask
   task t_parity();
      cyc_parity_read <= 1'b1;
      par(8'h01, 8'hFE, 4'b1011);
      par(8'h01, 8'h01, 4'b1111);
      @(posedge pclk) cyc_parity_read <= 1'b0;
      par(8'h01, 8'hFE, 4'b1111);
      apb(1'b0, `CSB_PERR_OFS, 32'h0);
      `CHK(rd[15:0], 16'h0001)
   endtask
   task t_smi();
      u_cs.pins(1'b1, 1'b1, 1'b1);
      u_cs.irq(1'b1);
      ck(4);
      bnd();
      ck(8);
      `CHK(sysmgmt_active_n, 1'b1)
      u_cs.pins(1'b1, 1'b1, 1'b0);
      for (i = 0; i < 8 && sysmgmt_active_n !== 1'b0; i++) @(negedge pclk);
      `CHK({sysmgmt_active_n, jump_addr}, {1'b0, 32'h0003_8000})
      u_cs.irq(1'b0);
      u_cs.irq(1'b1);
      ck(4);
      bnd();
      `CHK(s, 1'b0)
      done(1'b1);
      ck(2);
      `CHK(sysmgmt_active_n, 1'b1)
      bnd();
      for (i = 0; i < 8 && sysmgmt_active_n !== 1'b0; i++) @(negedge pclk);
      `CHK(sysmgmt_active_n, 1'b0)
      done(1'b1);
   endtask
   task t_reset(input logic sel);
      @(posedge pclk) {reset_in, tristate_test_select_n} <= {1'b1, sel};
      ck(16);
      `CHK({core_flush, jump_addr}, {1'b1, 32'hFFFF_FFF0})
      reset_in <= 1'b0;
      ck(8);
      `CHK({tristate_mode, parity_err_oe, core_flush}, {~sel, sel, 1'b0})
      apb(1'b0, `CSB_CTRL_OFS, 32'h0);
      `CHK(rd, 32'h0000_0000)
   endtask

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, reset_in} = '0;
      {cyc_start, cyc, cyc_last_ready, lock_seq_last, cyc_parity_read} = '0;
      {hold_ack, instr_boundary, irq_return_done, sysmgmt_exit_done} = '0;
      {bus_idle, tristate_test_select_n} = 2'b11;
      ck(3);
      presetn <= 1'b1;
      t_regs();
      t_urgent();
      t_attr();
      t_split();
      t_parity();
      t_smi();
      t_reset(1'b0);
      t_reset(1'b1);
      close_out();
   end

   initial begin
      ck(5000);
      n_fail++;
      close_out();
   end
endmodule

`default_nettype wire
